// ---- verilog/clisr_pkg.sv ----
package clisr_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 8;

  // byte offsets of the link interface map, one aligned word each
  localparam logic [ADDR_W-1:0] OFF_INTR        = 7'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS      = 7'h04;
  localparam logic [ADDR_W-1:0] OFF_CONFIG      = 7'h08;
  localparam logic [ADDR_W-1:0] OFF_CTRL_INDEX  = 7'h0C;
  localparam logic [ADDR_W-1:0] OFF_RX_CTRL     = 7'h10;
  localparam logic [ADDR_W-1:0] OFF_TX_CTRL     = 7'h14;
  localparam logic [ADDR_W-1:0] OFF_LCV         = 7'h18;
  localparam logic [ADDR_W-1:0] OFF_RX_FRAME    = 7'h1C;
  localparam logic [ADDR_W-1:0] OFF_HW_RESET    = 7'h20;
  localparam logic [ADDR_W-1:0] OFF_PHY_LOOP    = 7'h24;
  localparam logic [ADDR_W-1:0] OFF_MGMT_CFG    = 7'h28;
  localparam logic [ADDR_W-1:0] OFF_MGMT_STAT   = 7'h2C;
  localparam logic [ADDR_W-1:0] OFF_RXDLY_CTRL  = 7'h30;
  localparam logic [ADDR_W-1:0] OFF_RXDLY       = 7'h34;
  localparam logic [ADDR_W-1:0] OFF_ROUND_DLY   = 7'h38;
  localparam logic [ADDR_W-1:0] OFF_EXDLY_CFG   = 7'h3C;
  localparam logic [ADDR_W-1:0] OFF_EXDLY_STAT  = 7'h40;
  localparam logic [ADDR_W-1:0] OFF_RESERVED    = 7'h44;
  localparam logic [ADDR_W-1:0] OFF_RATE_CFG    = 7'h48;
  localparam logic [ADDR_W-1:0] OFF_INTR_PEND   = 7'h4C;

  // interrupt control fields
  localparam int INTR_EN_BIT     = 0;
  localparam int HWRST_EN_BIT    = 1;
  localparam int LOSLCV_EN_BIT   = 5;
  localparam logic [DATA_W-1:0] INTR_WR_MASK = 32'h00000023;

  // status fields
  localparam int ST_RXLOS   = 0;
  localparam int ST_RXSTATE = 1;
  localparam int ST_HFN     = 2;
  localparam int ST_BFN     = 3;
  localparam int ST_LOSLCV  = 5;
  localparam int ST_HOLD_LO = 8;
  localparam int HOLD_W     = 4;
  // hold vector order: 3 frame pulse, 2 clock mismatch, 1 sync, 0 loss
  localparam int H_RFP  = 3;
  localparam int H_FREQ = 2;
  localparam int H_SYNC = 1;
  localparam int H_LOS  = 0;

  localparam logic [DATA_W-1:0] CONFIG_WR_MASK = 32'h0000003F;
  localparam logic [CNT_W-1:0]  LCV_LIMIT      = 8'h0F;

  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;
  localparam logic [HOLD_W-1:0] HOLD_ZERO = 4'h0;

  // storage slots of the plain read/write words
  localparam int SLOT_CTRL_INDEX = 0;
  localparam int SLOT_TX_CTRL    = 1;
  localparam int SLOT_HW_RESET   = 2;
  localparam int SLOT_PHY_LOOP   = 3;
  localparam int SLOT_MGMT_CFG   = 4;
  localparam int SLOT_RXDLY_CTRL = 5;
  localparam int SLOT_EXDLY_CFG  = 6;
  localparam int SLOT_RATE_CFG   = 7;
  localparam int N_SLOT          = 8;
  localparam int SLOT_W          = 3;

endpackage

// ---- verilog/clisr_regs.sv ----
// Functional notes
// - decode twenty word offsets, 0x44 reserved
// - index selects word; rx 0x10, tx 0x14
// - hardware reset control word at 0x20
// - delay control and status at 0x30-0x40
// - bits 1 and 5 gate their interrupts
// - bit 0 enables link module interrupt
// - frame pulse sets read-to-clear bit 11
// - clock mismatch sets read-to-clear bit 10
// - sync only when rx, hfn, bfn achieved
// - loss when lcv above 15 or pin
`timescale 1ns/1ps
`default_nettype none

module clisr_regs (
  input  wire  logic                          mclk,
  input  wire  logic                          reset,
  input  wire  logic [clisr_pkg::ADDR_W-1:0]  cpu_address,
  input  wire  logic                          cpu_read,
  input  wire  logic                          cpu_write,
  input  wire  logic [clisr_pkg::DATA_W-1:0]  cpu_writedata,
  output var   logic [clisr_pkg::DATA_W-1:0]  cpu_readdata,
  output var   logic                          cpu_readdatavalid,
  output var   logic                          cpu_irq,
  input  wire  logic                          rx_frame_pulse,
  input  wire  logic                          rx_freq_mismatch,
  input  wire  logic                          rx_sync_done,
  input  wire  logic                          rx_hfn_sync,
  input  wire  logic                          rx_bfn_sync,
  input  wire  logic [clisr_pkg::CNT_W-1:0]   lcv_count,
  input  wire  logic                          optical_los_pin,
  input  wire  logic                          los_lcv_alarm,
  input  wire  logic                          remote_reset_req,
  input  wire  logic [clisr_pkg::DATA_W-1:0]  rx_ctrl_word,
  input  wire  logic [clisr_pkg::DATA_W-1:0]  lcv_counter_val,
  input  wire  logic [clisr_pkg::DATA_W-1:0]  rx_frame_count,
  input  wire  logic [clisr_pkg::DATA_W-1:0]  mgmt_status_val,
  input  wire  logic [clisr_pkg::DATA_W-1:0]  rx_delay_val,
  input  wire  logic [clisr_pkg::DATA_W-1:0]  round_delay_val,
  input  wire  logic [clisr_pkg::DATA_W-1:0]  ex_delay_status_val,
  input  wire  logic [clisr_pkg::DATA_W-1:0]  intr_pending_val,
  output var   logic [clisr_pkg::DATA_W-1:0]  link_config,
  output var   logic [clisr_pkg::DATA_W-1:0]  ctrl_word_index,
  output var   logic [clisr_pkg::DATA_W-1:0]  tx_ctrl_word,
  output var   logic [clisr_pkg::DATA_W-1:0]  hw_reset_ctrl,
  output var   logic [clisr_pkg::DATA_W-1:0]  phy_loop_ctrl,
  output var   logic [clisr_pkg::DATA_W-1:0]  mgmt_config,
  output var   logic [clisr_pkg::DATA_W-1:0]  rx_delay_ctrl,
  output var   logic [clisr_pkg::DATA_W-1:0]  ex_delay_config,
  output var   logic [clisr_pkg::DATA_W-1:0]  rate_config
);
  import clisr_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0]             intr;
    logic [HOLD_W-1:0]             hold;
    logic [DATA_W-1:0]             config_w;
    logic [N_SLOT-1:0][DATA_W-1:0] words;
    logic [DATA_W-1:0]             rdata;
    logic                          rvalid;
    logic                          irq;
    logic                          los_s1;
    logic                          los_s2;
  } clisr_state_t;

  clisr_state_t s_q;
  clisr_state_t s_d;

  logic              rx_state_live;
  logic              los_live;
  logic [HOLD_W-1:0] hold_set;
  logic              rd_status;
  logic [DATA_W-1:0] status_word;
  logic              slot_hit;
  logic [SLOT_W-1:0] slot_idx;

  assign rx_state_live = rx_sync_done & rx_hfn_sync & rx_bfn_sync;
  assign los_live      = (lcv_count > LCV_LIMIT) | s_q.los_s2;
  assign hold_set      = {rx_frame_pulse, rx_freq_mismatch, rx_state_live, los_live};
  assign rd_status     = cpu_read && (cpu_address == OFF_STATUS);

  always_comb begin
    status_word = WORD_ZERO;
    status_word[ST_HOLD_LO +: HOLD_W] = s_q.hold;
    status_word[ST_LOSLCV]  = los_lcv_alarm;
    status_word[ST_BFN]     = rx_bfn_sync;
    status_word[ST_HFN]     = rx_hfn_sync;
    status_word[ST_RXSTATE] = rx_state_live;
    status_word[ST_RXLOS]   = los_live;
  end

  // plain read/write words share one storage array
  always_comb begin
    slot_hit = 1'b1;
    slot_idx = SLOT_W'(SLOT_CTRL_INDEX);
    unique case (cpu_address)
      OFF_CTRL_INDEX: slot_idx = SLOT_W'(SLOT_CTRL_INDEX);
      OFF_TX_CTRL:    slot_idx = SLOT_W'(SLOT_TX_CTRL);
      OFF_HW_RESET:   slot_idx = SLOT_W'(SLOT_HW_RESET);
      OFF_PHY_LOOP:   slot_idx = SLOT_W'(SLOT_PHY_LOOP);
      OFF_MGMT_CFG:   slot_idx = SLOT_W'(SLOT_MGMT_CFG);
      OFF_RXDLY_CTRL: slot_idx = SLOT_W'(SLOT_RXDLY_CTRL);
      OFF_EXDLY_CFG:  slot_idx = SLOT_W'(SLOT_EXDLY_CFG);
      OFF_RATE_CFG:   slot_idx = SLOT_W'(SLOT_RATE_CFG);
      default:        slot_hit = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.los_s1 = optical_los_pin;
    s_d.los_s2 = s_q.los_s1;

    // a read clears the hold bits, an event in the same cycle still lands
    s_d.hold = (rd_status ? HOLD_ZERO : s_q.hold) | hold_set;

    if (cpu_write) begin
      if (cpu_address == OFF_INTR) begin
        s_d.intr = cpu_writedata & INTR_WR_MASK;
      end else if (cpu_address == OFF_CONFIG) begin
        s_d.config_w = cpu_writedata & CONFIG_WR_MASK;
      end else if (slot_hit) begin
        s_d.words[slot_idx] = cpu_writedata;
      end
    end

    if (cpu_read) begin
      s_d.rvalid = 1'b1;
      unique case (cpu_address)
        OFF_INTR:       s_d.rdata = s_q.intr;
        OFF_STATUS:     s_d.rdata = status_word;
        OFF_CONFIG:     s_d.rdata = s_q.config_w;
        OFF_RX_CTRL:    s_d.rdata = rx_ctrl_word;
        OFF_LCV:        s_d.rdata = lcv_counter_val;
        OFF_RX_FRAME:   s_d.rdata = rx_frame_count;
        OFF_MGMT_STAT:  s_d.rdata = mgmt_status_val;
        OFF_RXDLY:      s_d.rdata = rx_delay_val;
        OFF_ROUND_DLY:  s_d.rdata = round_delay_val;
        OFF_EXDLY_STAT: s_d.rdata = ex_delay_status_val;
        OFF_INTR_PEND:  s_d.rdata = intr_pending_val;
        // reserved slot and unmapped offsets answer with zero
        default:        s_d.rdata = slot_hit ? s_q.words[slot_idx] : WORD_ZERO;
      endcase
    end

    // module enable is a master gate over both sources
    s_d.irq = s_q.intr[INTR_EN_BIT] &
              ((s_q.intr[HWRST_EN_BIT] & remote_reset_req) |
               (s_q.intr[LOSLCV_EN_BIT] & los_lcv_alarm));
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cpu_readdata      = s_q.rdata;
  assign cpu_readdatavalid = s_q.rvalid;
  assign cpu_irq           = s_q.irq;
  assign link_config       = s_q.config_w;
  assign ctrl_word_index   = s_q.words[SLOT_CTRL_INDEX];
  assign tx_ctrl_word      = s_q.words[SLOT_TX_CTRL];
  assign hw_reset_ctrl     = s_q.words[SLOT_HW_RESET];
  assign phy_loop_ctrl     = s_q.words[SLOT_PHY_LOOP];
  assign mgmt_config       = s_q.words[SLOT_MGMT_CFG];
  assign rx_delay_ctrl     = s_q.words[SLOT_RXDLY_CTRL];
  assign ex_delay_config   = s_q.words[SLOT_EXDLY_CFG];
  assign rate_config       = s_q.words[SLOT_RATE_CFG];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence seq_status_read_quiet;
    rd_status && (hold_set == HOLD_ZERO);
  endsequence

  sequence seq_word_written(logic [ADDR_W-1:0] off);
    cpu_write && (cpu_address == off);
  endsequence

  chk_rc_read_clear: assert property (
    seq_status_read_quiet |=> (s_q.hold == HOLD_ZERO))
    else $error("status hold bits not cleared by read");

  chk_rfp_set_wins: assert property (
    rx_frame_pulse |=> s_q.hold[H_RFP])
    else $error("frame pulse hold bit lost");

  chk_freq_hold_sticky: assert property (
    (rx_freq_mismatch ##1 (!rd_status)[*2]) |=> s_q.hold[H_FREQ])
    else $error("clock mismatch hold bit not sticky");

  chk_irq_master_off: assert property (
    !s_q.intr[INTR_EN_BIT] |=> !cpu_irq)
    else $error("interrupt raised with module enable clear");

  chk_hwrst_irq_gate: assert property (
    (s_q.intr[INTR_EN_BIT] && s_q.intr[HWRST_EN_BIT] && remote_reset_req) |=>
      cpu_irq)
    else $error("remote reset interrupt gating wrong");

  chk_loslcv_irq_gate: assert property (
    (!s_q.intr[LOSLCV_EN_BIT] && !remote_reset_req) |=> !cpu_irq)
    else $error("loss interrupt raised with its enable clear");

  chk_sync_read_and: assert property (
    rd_status |=> cpu_readdatavalid &&
      (cpu_readdata[ST_RXSTATE] == $past(rx_sync_done && rx_hfn_sync && rx_bfn_sync)))
    else $error("sync status not the and of three");

  chk_los_threshold: assert property (
    (rd_status && (lcv_count > LCV_LIMIT)) |=> cpu_readdata[ST_RXLOS])
    else $error("loss not shown above line code limit");

  chk_reserved_zero: assert property (
    (cpu_read && (cpu_address == OFF_RESERVED)) |=>
      cpu_readdatavalid && (cpu_readdata == WORD_ZERO))
    else $error("reserved slot not read as zero");

  chk_index_write: assert property (
    seq_word_written(OFF_CTRL_INDEX) |=> (ctrl_word_index == $past(cpu_writedata)))
    else $error("control word index not stored");

  chk_hwrst_write: assert property (
    seq_word_written(OFF_HW_RESET) |=> (hw_reset_ctrl == $past(cpu_writedata)))
    else $error("hardware reset control not stored");

  chk_delay_write: assert property (
    (seq_word_written(OFF_RXDLY_CTRL) ##1 (cpu_read && (cpu_address == OFF_RXDLY_CTRL)))
      |=> (cpu_readdata == $past(cpu_writedata, 2)))
    else $error("receiver delay control readback wrong");

  sequence seq_word_read(logic [ADDR_W-1:0] off);
    cpu_read && (cpu_address == off);
  endsequence

  chk_hwrst_irq_off: assert property (
    (!s_q.intr[HWRST_EN_BIT] && !(s_q.intr[LOSLCV_EN_BIT] && los_lcv_alarm)) |=> !cpu_irq)
    else $error("remote reset interrupt raised with its enable clear");

  chk_loslcv_irq_on: assert property (
    (s_q.intr[INTR_EN_BIT] && s_q.intr[LOSLCV_EN_BIT] && los_lcv_alarm) |=> cpu_irq)
    else $error("loss interrupt missing with enables set");

  chk_intr_write_mask: assert property (
    seq_word_written(OFF_INTR) |=> (s_q.intr == ($past(cpu_writedata) & INTR_WR_MASK)))
    else $error("interrupt enables not stored or reserved bits kept");

  chk_freq_set_wins: assert property (
    rx_freq_mismatch |=> s_q.hold[H_FREQ])
    else $error("clock mismatch hold bit lost");

  chk_sync_hold_set: assert property (
    (rx_sync_done && rx_hfn_sync && rx_bfn_sync) |=> s_q.hold[H_SYNC])
    else $error("sync hold bit not set");

  chk_los_hold_set: assert property (
    (lcv_count > LCV_LIMIT) |=> s_q.hold[H_LOS])
    else $error("loss hold bit not set above limit");

  chk_pin_los_shown: assert property (
    (rd_status && s_q.los_s2) |=> cpu_readdata[ST_RXLOS])
    else $error("loss not shown with optical pin active");

  chk_read_valid_once: assert property (
    cpu_read |=> cpu_readdatavalid)
    else $error("read not answered with valid");

  chk_no_stray_valid: assert property (
    !cpu_read |=> !cpu_readdatavalid)
    else $error("read valid without a read");

  chk_status_reserved: assert property (
    rd_status |=> ((cpu_readdata[DATA_W-1:ST_HOLD_LO+HOLD_W] == '0) &&
      (cpu_readdata[ST_HOLD_LO-1:ST_LOSLCV+1] == '0) && !cpu_readdata[ST_LOSLCV-1]))
    else $error("reserved status bits not zero");

  chk_config_write: assert property (
    seq_word_written(OFF_CONFIG) |=> (link_config == ($past(cpu_writedata) & CONFIG_WR_MASK)))
    else $error("configuration word not stored");

  chk_reserved_write: assert property (
    seq_word_written(OFF_RESERVED) |=>
      ($stable(s_q.words) && $stable(s_q.intr) && $stable(s_q.config_w)))
    else $error("write to reserved slot changed a register");

  chk_tx_ctrl_write: assert property (
    seq_word_written(OFF_TX_CTRL) |=> (tx_ctrl_word == $past(cpu_writedata)))
    else $error("transmit control word not stored");

  chk_rx_ctrl_read: assert property (
    seq_word_read(OFF_RX_CTRL) |=> (cpu_readdata == $past(rx_ctrl_word)))
    else $error("received control word readback wrong");

  chk_exdly_read: assert property (
    seq_word_read(OFF_EXDLY_STAT) |=> (cpu_readdata == $past(ex_delay_status_val)))
    else $error("extended delay status readback wrong");

endmodule

`default_nettype wire

// ---- verification/clisr_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module clisr_regs_test;
  import clisr_pkg::*;
  logic              mclk;
  logic              reset;
  logic [6:0]        cpu_address;
  logic              cpu_read;
  logic              cpu_write;
  logic [31:0]       cpu_writedata;
  logic [31:0]       cpu_readdata;
  logic              cpu_readdatavalid;
  logic              cpu_irq;
  logic              rfp, freq, sync, hfn, bfn, pin, alarm, rreq;
  logic [7:0]        lcv;
  logic [31:0]       ro_val [8];
  logic [31:0]       rw_q [8];
  logic [31:0]       d;
  logic [31:0]       v;
  logic [31:0]       link_cfg;
  logic [31:0]       seed = 32'h000121B8;
  int                miscompares, samples_checked, cycles;
  logic [6:0] ro_off [8] = '{7'h10, 7'h18, 7'h1C, 7'h2C, 7'h34, 7'h38, 7'h40, 7'h4C};
  logic [6:0] rw_off [8] = '{7'h0C, 7'h14, 7'h20, 7'h24, 7'h28, 7'h30, 7'h3C, 7'h48};
  logic [6:0] bad_off [4] = '{7'h44, 7'h50, 7'h06, 7'h7C};
  // corners carry their own source levels in bits 9:8
  logic [31:0] irq_en [4] = '{32'h00000323, 32'h00000121, 32'h00000221, 32'h00000322};

  clisr_regs DUT (.mclk(mclk), .reset(reset), .cpu_address(cpu_address),
    .cpu_read(cpu_read), .cpu_write(cpu_write), .cpu_writedata(cpu_writedata),
    .cpu_readdata(cpu_readdata), .cpu_readdatavalid(cpu_readdatavalid), .cpu_irq(cpu_irq),
    .rx_frame_pulse(rfp), .rx_freq_mismatch(freq), .rx_sync_done(sync), .rx_hfn_sync(hfn),
    .rx_bfn_sync(bfn), .lcv_count(lcv), .optical_los_pin(pin), .los_lcv_alarm(alarm),
    .remote_reset_req(rreq), .rx_ctrl_word(ro_val[0]), .lcv_counter_val(ro_val[1]),
    .rx_frame_count(ro_val[2]), .mgmt_status_val(ro_val[3]), .rx_delay_val(ro_val[4]),
    .round_delay_val(ro_val[5]), .ex_delay_status_val(ro_val[6]),
    .intr_pending_val(ro_val[7]), .link_config(link_cfg), .ctrl_word_index(rw_q[0]),
    .tx_ctrl_word(rw_q[1]), .hw_reset_ctrl(rw_q[2]), .phy_loop_ctrl(rw_q[3]),
    .mgmt_config(rw_q[4]), .rx_delay_ctrl(rw_q[5]), .ex_delay_config(rw_q[6]),
    .rate_config(rw_q[7]));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic irq_exp(input logic [31:0] en, input logic r, input logic a);
    return en[0] & ((en[1] & r) | (en[5] & a));
  endfunction

  // hold order: frame pulse, clock mismatch, sync, loss
  function automatic logic [31:0] st_exp(input logic [3:0] h, input logic s, input logic hf,
                                         input logic bf, input logic l, input logic a);
    return {20'h00000, h, 2'h0, a, 1'b0, bf, hf, s & hf & bf, l};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] dat);
    @(posedge mclk);
    cpu_write     <= 1'b1;
    cpu_address   <= a;
    cpu_writedata <= dat;
    @(posedge mclk);
    cpu_write <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [6:0] a, output logic [31:0] dat);
    @(posedge mclk);
    cpu_read    <= 1'b1;
    cpu_address <= a;
    @(posedge mclk);
    cpu_read <= 1'b0;
    #1;
    dat = cpu_readdata;
    chk({31'h0, cpu_readdatavalid}, 32'h00000001, "read valid");
  endtask

  task automatic summarize();
    $display("checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    {cpu_address, cpu_read, cpu_write, cpu_writedata} = '0;
    {rfp, freq, sync, hfn, bfn, pin, alarm, rreq, lcv} = '0;
    foreach (ro_val[i]) ro_val[i] = 32'h00000000;
    reset = 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    foreach (ro_val[i]) ro_val[i] <= rnd();
    rd(7'h04, d);
    chk(d, 32'h00000000, "status after reset");
    foreach (rw_off[i]) begin
      v = rnd();
      wr(rw_off[i], v);
      chk(rw_q[i], v, "rw port");
      rd(rw_off[i], d);
      chk(d, v, "rw readback");
    end
    foreach (ro_off[i]) begin
      wr(ro_off[i], ~ro_val[i]);
      rd(ro_off[i], d);
      chk(d, ro_val[i], "ro word");
    end
    foreach (bad_off[i]) begin
      wr(bad_off[i], rnd());
      rd(bad_off[i], d);
      chk(d, 32'h00000000, "reserved or unmapped");
    end
    wr(7'h00, 32'hFFFFFFFF);
    rd(7'h00, d);
    chk(d, 32'h00000023, "intr fields");
    v = rnd();
    wr(7'h08, v);
    chk(link_cfg, v & CONFIG_WR_MASK, "config port");
    rd(7'h08, d);
    chk(d, v & CONFIG_WR_MASK, "config readback");
    $display("test map done");
    for (int k = 0; k < 16; k++) begin
      v = (k < 4) ? irq_en[k] : rnd();
      wr(7'h00, v);
      rreq  <= v[8];
      alarm <= v[9];
      repeat (2) @(posedge mclk);
      #1;
      chk({31'h0, cpu_irq}, {31'h0, irq_exp(v, v[8], v[9])}, "irq");
    end
    rd(7'h04, d);
    chk(d, st_exp(4'h0, 1'b0, 1'b0, 1'b0, 1'b0, alarm), "alarm live");
    {rreq, alarm} <= 2'b00;
    $display("test irq done");
    @(posedge mclk);
    rfp <= 1'b1;
    @(posedge mclk);
    rfp  <= 1'b0;
    freq <= 1'b1;
    @(posedge mclk);
    freq <= 1'b0;
    rd(7'h04, d);
    chk(d, st_exp(4'hC, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0), "events held");
    rd(7'h04, d);
    chk(d, 32'h00000000, "events cleared");
    {sync, hfn, bfn} <= 3'b011;
    rd(7'h04, d);
    chk(d, st_exp(4'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0), "partial sync");
    sync <= 1'b1;
    rd(7'h04, d);
    rd(7'h04, d);
    chk(d, st_exp(4'h2, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0), "sync twice");
    {sync, hfn, bfn} <= 3'b000;
    rd(7'h04, d);
    chk(d, st_exp(4'h2, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0), "sync held");
    lcv <= 8'h0F;
    rd(7'h04, d);
    chk(d, 32'h00000000, "lcv limit");
    for (int k = 0; k < 2; k++) begin
      if (k == 0) lcv <= 8'h10;
      else pin <= 1'b1;
      repeat (4) @(posedge mclk);
      rd(7'h04, d);
      chk(d, st_exp(4'h1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0), "loss live");
      {lcv, pin} <= '0;
      repeat (4) @(posedge mclk);
      rd(7'h04, d);
      chk(d, st_exp(4'h1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0), "loss held");
      rd(7'h04, d);
      chk(d, 32'h00000000, "loss cleared");
    end
    $display("test status done");
    wr(7'h20, rnd());
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    #1;
    chk(rw_q[2], 32'h00000000, "hw reset word after reset");
    chk(link_cfg, 32'h00000000, "config after reset");
    rd(7'h00, d);
    chk(d, 32'h00000000, "intr after reset");
    $display("test reset done");
    summarize();
  end
endmodule

`default_nettype wire
